// ==== core/oas_pkg.sv ====
// Shared constants and types for the operand addressing and stack block
package oas_pkg;

	// ==========================================================
	// Widths and limits
	localparam int WORD_W      = 16;
	localparam int SHORT_IMM_W = 7;
	localparam int SHORT_ADR_W = 6;
	localparam int OFS6_W      = 6;
	localparam int PTR_IDX_W   = 2;
	localparam logic [15:0] SP_RESET   = 16'h0000;
	localparam logic [15:0] PTR_RESET  = 16'h0000;
	localparam logic [15:0] PERIPH_BASE = 16'hffc0;

	// ==========================================================
	// Operand modes for memory, peripheral, immediate and register moves
	typedef enum logic [3:0] {
		OAS_AM_IND_NOUPD,
		OAS_AM_IND_POSTINC,
		OAS_AM_IND_POSTDEC,
		OAS_AM_IND_POSTREG,
		OAS_AM_IND_OFS16,
		OAS_AM_IND_OFS6,
		OAS_AM_IND_IDXREG,
		OAS_AM_ABS16,
		OAS_AM_ABS6,
		OAS_AM_PERIPH6,
		OAS_AM_STACK_REL,
		OAS_AM_IMM16,
		OAS_AM_IMM7,
		OAS_AM_REG
	} oas_mode_t;

	// Operation requested of the addressing and stack logic
	typedef enum logic [2:0] {
		OAS_OP_NONE,
		OAS_OP_MOVE,
		OAS_OP_ADD,
		OAS_OP_CALL,
		OAS_OP_LEA_SP,
		OAS_OP_DECREMENT_MEMORY_WORD,
		OAS_OP_BGT
	} oas_op_t;

	// Decoded instruction fields from the core sequencer
	typedef struct packed {
		oas_op_t               op;
		oas_mode_t             mode;
		logic [PTR_IDX_W-1:0]  ptr;
		logic [5:0]            short_field;
		logic [SHORT_IMM_W-1:0] imm7;
		logic [WORD_W-1:0]     ext;
		logic [WORD_W-1:0]     reg_val;
		logic [3:0]            shift;
		logic                  shift_left;
	} oas_req_t;

	// Memory-side request
	typedef struct packed {
		logic              rd;
		logic              wr;
		logic              periph;
		logic [WORD_W-1:0] addr;
		logic [WORD_W-1:0] wdata;
	} oas_mem_t;

endpackage

// ==== core/oas_shifter.sv ====
// 16-bit barrel shifter for the operand path
`timescale 1ns/1ps
module oas_shifter
#(
	parameter int W = 16
)
(
	input  wire logic [W-1:0] i_data,
	input  wire logic [3:0]   i_amount,
	input  wire logic         i_left,
	input  wire logic         i_arith,
	output logic      [W-1:0] o_data
);

	// ==========================================================
	// Shift network
	// Single-cycle shift, either direction, optional sign fill
	always_comb
	begin
		if (i_left)
			o_data = i_data << i_amount;
		else if (i_arith)
			o_data = W'($signed(i_data) >>> i_amount);
		else
			o_data = i_data >> i_amount;
	end

endmodule

// ==== core/oas_core.sv ====
// Operand addressing and memory stack logic of the signal core
`timescale 1ns/1ps
module oas_core
#(
	parameter int NUM_PTR = 4
)
(
	input  wire logic              i_clock,
	input  wire logic              i_rst_n,
	input  wire logic              i_valid,
	input  wire oas_pkg::oas_req_t i_req,
	input  wire logic [15:0]       i_pc_ret,
	input  wire logic [15:0]       i_status,
	input  wire logic [15:0]       i_rdata,
	output oas_pkg::oas_mem_t      o_mem,
	output logic [15:0]            o_operand,
	output logic                   o_operand_vld,
	output logic [15:0]            o_sum,
	output logic                   o_carry,
	output logic                   o_branch_taken,
	output logic                   o_busy,
	output logic [15:0]            o_stack_pointer
);

	// ==========================================================
	// State
	typedef enum logic [1:0] {OAS_IDLE, OAS_CALL2, OAS_DECREMENT_MEMORY_WORD_WB} oas_st_t;

	oas_st_t            st_r, st_nxt;
	logic [15:0]        sp_r, sp_nxt;
	logic [15:0]        ptr_r   [NUM_PTR];
	logic [15:0]        ptr_nxt [NUM_PTR];
	oas_pkg::oas_mem_t  mem_r, mem_nxt;
	logic [15:0]        opnd_r, opnd_nxt;
	logic               opv_r, opv_nxt;
	logic [15:0]        sum_r, sum_nxt;
	logic               carry_r, carry_nxt;
	logic               bt_r, bt_nxt;
	logic [15:0]        last_r, last_nxt;
	logic [15:0]        dec_addr_r, dec_addr_nxt;
	logic [15:0]        ea;
	logic [15:0]        shifted;
	logic               is_mem;

	// Zero-extend a short field into a word
	function automatic logic [15:0] zext6(input logic [5:0] v);
		return {10'h000, v};
	endfunction

	// Sign-extend the compact immediate
	function automatic logic [15:0] sext7(input logic [6:0] v);
		return {{9{v[6]}}, v};
	endfunction

	// ==========================================================
	// Barrel shifter on the register operand
	oas_shifter #(.W(16)) u_shift
	(
		.i_data   (i_req.reg_val),
		.i_amount (i_req.shift),
		.i_left   (i_req.shift_left),
		.i_arith  (1'b0),
		.o_data   (shifted)
	);

	// ==========================================================
	// Effective address, fixed purely by mode encoding
	always_comb
	begin
		ea     = 16'h0000;
		is_mem = 1'b1;
		unique case (i_req.mode)
			oas_pkg::OAS_AM_IND_NOUPD,
			oas_pkg::OAS_AM_IND_POSTINC,
			oas_pkg::OAS_AM_IND_POSTDEC,
			oas_pkg::OAS_AM_IND_POSTREG: ea = ptr_r[i_req.ptr];
			oas_pkg::OAS_AM_IND_OFS16:
				ea = ptr_r[i_req.ptr] + i_req.ext;
			oas_pkg::OAS_AM_IND_OFS6:
				ea = ptr_r[i_req.ptr] + zext6(i_req.short_field);
			oas_pkg::OAS_AM_IND_IDXREG:
				ea = ptr_r[i_req.ptr] + i_req.reg_val;
			oas_pkg::OAS_AM_ABS16:  ea = i_req.ext;
			oas_pkg::OAS_AM_ABS6:   ea = zext6(i_req.short_field);
			oas_pkg::OAS_AM_PERIPH6:
				ea = oas_pkg::PERIPH_BASE | zext6(i_req.short_field);
			oas_pkg::OAS_AM_STACK_REL:
				ea = sp_r - zext6(i_req.short_field);
			default: is_mem = 1'b0; // Immediate and register modes
		endcase
	end

	// ==========================================================
	// Next-state for stack, pointers, memory request and results
	always_comb
	begin
		st_nxt       = OAS_IDLE;
		sp_nxt       = sp_r;
		ptr_nxt      = ptr_r;
		mem_nxt      = '0;
		opnd_nxt     = opnd_r;
		opv_nxt      = 1'b0;
		sum_nxt      = sum_r;
		carry_nxt    = carry_r;
		bt_nxt       = 1'b0;
		last_nxt     = last_r;
		dec_addr_nxt = dec_addr_r;
		unique case (st_r)
			OAS_CALL2:
			begin
				// Second push: status word above return address
				sp_nxt        = sp_r + 16'h0001;
				mem_nxt.wr    = 1'b1;
				mem_nxt.addr  = sp_r + 16'h0001;
				mem_nxt.wdata = i_status;
				st_nxt        = OAS_IDLE;
			end
			OAS_DECREMENT_MEMORY_WORD_WB:
			begin
				// Write back decremented word in place
				last_nxt      = i_rdata - 16'h0001;
				mem_nxt.wr    = 1'b1;
				mem_nxt.addr  = dec_addr_r;
				mem_nxt.wdata = i_rdata - 16'h0001;
				st_nxt        = OAS_IDLE;
			end
			default:
			begin
				if (i_valid)
				begin
					// Post-modify pointer after forming address
					unique case (i_req.mode)
						oas_pkg::OAS_AM_IND_POSTINC:
							ptr_nxt[i_req.ptr] = ptr_r[i_req.ptr] + 16'h0001;
						oas_pkg::OAS_AM_IND_POSTDEC:
							ptr_nxt[i_req.ptr] = ptr_r[i_req.ptr] - 16'h0001;
						oas_pkg::OAS_AM_IND_POSTREG:
							ptr_nxt[i_req.ptr] = ptr_r[i_req.ptr] + i_req.reg_val;
						default: ;
					endcase
					unique case (i_req.op)
						oas_pkg::OAS_OP_MOVE,
						oas_pkg::OAS_OP_ADD:
						begin
							// Memory read, or immediate or shifted register straight out
							mem_nxt.rd     = is_mem;
							mem_nxt.periph =
								i_req.mode == oas_pkg::OAS_AM_PERIPH6;
							mem_nxt.addr   = ea;
							opv_nxt        = ~is_mem;
							if (i_req.mode == oas_pkg::OAS_AM_IMM16)
								opnd_nxt = i_req.ext;
							else if (i_req.mode == oas_pkg::OAS_AM_IMM7)
								opnd_nxt = sext7(i_req.imm7);
							else
								opnd_nxt = shifted;
							if (i_req.op == oas_pkg::OAS_OP_ADD && !is_mem)
							begin
								// Unsigned add with carry out
								{carry_nxt, sum_nxt} = 17'({1'b0, i_req.reg_val}
									+ {1'b0, opnd_nxt});
							end
						end
						oas_pkg::OAS_OP_CALL:
						begin
							// First push: return address
							sp_nxt        = sp_r + 16'h0001;
							mem_nxt.wr    = 1'b1;
							mem_nxt.addr  = sp_r + 16'h0001;
							mem_nxt.wdata = i_pc_ret;
							st_nxt        = OAS_CALL2;
						end
						oas_pkg::OAS_OP_LEA_SP:
							sp_nxt = sp_r + i_req.reg_val;
						oas_pkg::OAS_OP_DECREMENT_MEMORY_WORD:
						begin
							mem_nxt.rd   = 1'b1;
							mem_nxt.addr = ea;
							dec_addr_nxt = ea;
							st_nxt       = OAS_DECREMENT_MEMORY_WORD_WB;
						end
						oas_pkg::OAS_OP_BGT:
							// Signed positive and nonzero
							bt_nxt = !last_r[15] && last_r != 16'h0000;
						default: ;
					endcase
				end
			end
		endcase
	end

	// ==========================================================
	// Registers; all outputs straight from flops except o_busy, decoded from st_r
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			st_r       <= OAS_IDLE;
			sp_r       <= oas_pkg::SP_RESET;
			for (int i = 0; i < NUM_PTR; i++)
				ptr_r[i] <= oas_pkg::PTR_RESET;
			mem_r      <= '0;
			opnd_r     <= 16'h0000;
			opv_r      <= 1'b0;
			sum_r      <= 16'h0000;
			carry_r    <= 1'b0;
			bt_r       <= 1'b0;
			last_r     <= 16'h0000;
			dec_addr_r <= 16'h0000;
		end
		else
		begin
			st_r       <= st_nxt;
			sp_r       <= sp_nxt;
			ptr_r      <= ptr_nxt;
			mem_r      <= mem_nxt;
			opnd_r     <= opnd_nxt;
			opv_r      <= opv_nxt;
			sum_r      <= sum_nxt;
			carry_r    <= carry_nxt;
			bt_r       <= bt_nxt;
			last_r     <= last_nxt;
			dec_addr_r <= dec_addr_nxt;
		end
	end

	assign o_mem           = mem_r;
	assign o_operand       = opnd_r;
	assign o_operand_vld   = opv_r;
	assign o_sum           = sum_r;
	assign o_carry         = carry_r;
	assign o_branch_taken  = bt_r;
	assign o_busy          = st_r != OAS_IDLE;
	assign o_stack_pointer = sp_r;

	// ==========================================================
	// Checks
	sequence s_call_req;
		i_valid && st_r == OAS_IDLE && i_req.op == oas_pkg::OAS_OP_CALL;
	endsequence
	sequence s_two_pushes;
		mem_r.wr && mem_r.wdata == $past(i_pc_ret) ##1
		mem_r.wr && mem_r.wdata == $past(i_status);
	endsequence

	AST_CALL_PUSHES: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		s_call_req |=> s_two_pushes)
		else $error("call did not push return and status");
	AST_CALL_SP: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		s_call_req |-> ##2 sp_r == $past(sp_r, 2) + 16'h0002)
		else $error("call stack pointer step wrong");
	AST_LEA_SP: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		i_valid && st_r == OAS_IDLE && i_req.op == oas_pkg::OAS_OP_LEA_SP
		|=> sp_r == $past(sp_r) + $past(i_req.reg_val))
		else $error("stack pointer not raised by offset");
	AST_STACK_REL: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		i_valid && st_r == OAS_IDLE && i_req.op == oas_pkg::OAS_OP_MOVE
		&& i_req.mode == oas_pkg::OAS_AM_STACK_REL
		|=> mem_r.rd && mem_r.addr == $past(sp_r) - {10'h000,
			$past(i_req.short_field)} && sp_r == $past(sp_r))
		else $error("stack operand address wrong");
	AST_SHORT_DIRECT: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		mem_r.rd && !mem_r.periph && $past(i_req.mode)
		== oas_pkg::OAS_AM_ABS6 && $past(st_r) == OAS_IDLE
		|-> mem_r.addr < 16'h0040)
		else $error("short direct left low memory");
	AST_PERIPH: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		mem_r.periph |-> mem_r.rd && mem_r.addr[15:6] == 10'h3ff)
		else $error("peripheral address outside window");
	AST_POSTINC: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		i_valid && st_r == OAS_IDLE && i_req.op == oas_pkg::OAS_OP_MOVE
		&& i_req.mode == oas_pkg::OAS_AM_IND_POSTINC
		|=> mem_r.addr + 16'h0001 == ptr_r[$past(i_req.ptr)])
		else $error("post increment wrong");
	AST_OFS_KEEPS_PTR: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		i_valid && st_r == OAS_IDLE && i_req.op == oas_pkg::OAS_OP_MOVE
		&& i_req.mode == oas_pkg::OAS_AM_IND_OFS16
		|=> ptr_r[$past(i_req.ptr)] == $past(ptr_r[i_req.ptr]))
		else $error("indexed mode moved pointer");
	AST_DECREMENT_MEMORY_WORD: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		st_r == OAS_DECREMENT_MEMORY_WORD_WB |=> mem_r.wr && mem_r.wdata
		== $past(i_rdata) - 16'h0001)
		else $error("decrement write back wrong");
	AST_BGT: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		bt_r |-> !$past(last_r[15]) && $past(last_r) != 16'h0000)
		else $error("branch taken on nonpositive");

endmodule

// ==== verification/oas_x_data_ram_model.sv ====
// X data memory and peripheral register model for the bench
`timescale 1ns/1ps
module oas_x_data_ram_model
(
	input  wire logic              i_clock,
	input  wire oas_pkg::oas_mem_t i_mem,
	output logic [15:0]            o_rdata
);
	logic [15:0] ram [0:255];
	logic [15:0] last_r;

	// ==========================================================
	// Storage
	// Word k starts as k so every read is predictable
	initial
	begin
		for (int k = 0; k < 256; k++)
			ram[k] = k[15:0];
		last_r = 16'h0000;
	end

	// Writes land on the edge; stack words live here too
	always @(posedge i_clock)
	begin
		if (i_mem.wr && !i_mem.periph)
			ram[i_mem.addr[7:0]] <= i_mem.wdata;
		if (i_mem.rd)
			last_r <= o_rdata;
	end

	// Idle bus shows the inverse of the last value, never a stale copy
	always_comb
	begin
		if (!i_mem.rd)
			o_rdata = ~last_r;
		else if (i_mem.periph)
			o_rdata = ~i_mem.addr;
		else
			o_rdata = ram[i_mem.addr[7:0]];
	end
endmodule

// ==== verification/operand_addressing_stack_test.sv ====
// Self-checking bench for the operand addressing and stack block
`timescale 1ns/1ps
module operand_addressing_stack_test;
	logic              i_clock;
	logic              i_rst_n;
	logic              i_valid;
	oas_pkg::oas_req_t i_req;
	logic [15:0]       i_pc_ret;
	logic [15:0]       i_status;
	logic [15:0]       i_rdata;
	oas_pkg::oas_mem_t o_mem;
	logic [15:0]       o_operand;
	logic [15:0]       o_sum;
	logic [15:0]       o_stack_pointer;
	logic              o_operand_vld;
	logic              o_carry;
	logic              o_branch_taken;
	logic              o_busy;
	int                fails;
	int                n_tests;
	int                cycles;

	// ==========================================================
	// Design and far side
	oas_core i_dut (.i_clock(i_clock), .i_rst_n(i_rst_n),
		.i_valid(i_valid), .i_req(i_req), .i_pc_ret(i_pc_ret),
		.i_status(i_status), .i_rdata(i_rdata), .o_mem(o_mem),
		.o_operand(o_operand), .o_operand_vld(o_operand_vld),
		.o_sum(o_sum), .o_carry(o_carry),
		.o_branch_taken(o_branch_taken), .o_busy(o_busy),
		.o_stack_pointer(o_stack_pointer));
	oas_x_data_ram_model i_mem (.i_clock(i_clock), .i_mem(o_mem),
		.o_rdata(i_rdata));

	// 50 ns clock and a hang limit well past the run length
	always #25 i_clock = ~i_clock;
	always @(posedge i_clock)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			fails++;
			finish_test();
		end
	end

	// ==========================================================
	// Shared tasks
	task automatic chk(input logic [17:0] got, input logic [17:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One request; returns just after the answer edge
	task automatic issue(input oas_pkg::oas_op_t op,
		input oas_pkg::oas_mode_t md, input logic [1:0] p,
		input logic [5:0] sf, input logic [15:0] ext, rv);
		@(posedge i_clock);
		#1;
		i_req = '0;
		i_req.op = op;
		i_req.mode = md;
		i_req.ptr = p;
		i_req.short_field = sf;
		i_req.imm7 = ext[6:0];
		i_req.ext = ext;
		i_req.reg_val = rv;
		i_req.shift = sf[3:0];
		i_req.shift_left = sf[4];
		i_valid = 1'b1;
		@(posedge i_clock);
		#1;
		i_valid = 1'b0;
	endtask

	// Strobe, window flag and address of the memory request
	function automatic logic [17:0] acc();
		return {o_mem.rd | o_mem.wr, o_mem.periph, o_mem.addr};
	endfunction

	task automatic finish_test();
		$display("fails=%0d n_tests=%0d", fails, n_tests);
		if (fails == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_immediate();
		issue(oas_pkg::OAS_OP_MOVE, oas_pkg::OAS_AM_IMM16, 0, 0, 16'h8123, 0);
		chk({o_operand_vld, o_operand}, 18'h18123);
		issue(oas_pkg::OAS_OP_MOVE, oas_pkg::OAS_AM_IMM7, 0, 0, 16'h0041, 0);
		chk({o_operand_vld, o_operand}, 18'h1ffc1);
		issue(oas_pkg::OAS_OP_MOVE, oas_pkg::OAS_AM_REG, 0, 6'h13, 0, 16'h8001);
		chk({o_operand_vld, o_operand}, 18'h10008);
		issue(oas_pkg::OAS_OP_MOVE, oas_pkg::OAS_AM_REG, 0, 6'h04, 0, 16'h8001);
		chk({o_operand_vld, o_operand}, 18'h10800);
	endtask

	// Unsigned add, carry out of the top bit
	task automatic t_add();
		issue(oas_pkg::OAS_OP_ADD, oas_pkg::OAS_AM_IMM16, 0, 0, 16'h0002, 16'hffff);
		chk({o_carry, o_sum}, 18'h10001);
		issue(oas_pkg::OAS_OP_ADD, oas_pkg::OAS_AM_IMM7, 0, 0, 16'h0005, 16'h0010);
		chk({o_carry, o_sum}, 18'h00015);
	endtask

	task automatic t_direct();
		issue(oas_pkg::OAS_OP_MOVE, oas_pkg::OAS_AM_ABS16, 0, 0, 16'h1234, 0);
		chk(acc(), 18'h21234);
		issue(oas_pkg::OAS_OP_MOVE, oas_pkg::OAS_AM_ABS6, 0, 6'h3f, 16'hff00, 0);
		chk(acc(), 18'h2003f);
		issue(oas_pkg::OAS_OP_MOVE, oas_pkg::OAS_AM_PERIPH6, 0, 6'h05, 0, 0);
		chk(acc(), 18'h3ffc5);
		issue(oas_pkg::OAS_OP_MOVE, oas_pkg::OAS_AM_IND_OFS6, 2, 6'h09, 0, 0);
		chk(acc(), 18'h20009);
	endtask

	// Pointer 1 walked through every update kind
	task automatic t_pointer();
		issue(oas_pkg::OAS_OP_MOVE, oas_pkg::OAS_AM_IND_POSTINC, 1, 0, 0, 0);
		chk(acc(), 18'h20000);
		issue(oas_pkg::OAS_OP_MOVE, oas_pkg::OAS_AM_IND_POSTINC, 1, 0, 0, 0);
		chk(acc(), 18'h20001);
		issue(oas_pkg::OAS_OP_MOVE, oas_pkg::OAS_AM_IND_POSTDEC, 1, 0, 0, 0);
		chk(acc(), 18'h20002);
		issue(oas_pkg::OAS_OP_MOVE, oas_pkg::OAS_AM_IND_POSTREG, 1, 0, 0, 16'h0010);
		chk(acc(), 18'h20001);
		issue(oas_pkg::OAS_OP_MOVE, oas_pkg::OAS_AM_IND_IDXREG, 1, 0, 0, 16'h0005);
		chk(acc(), 18'h20016);
		issue(oas_pkg::OAS_OP_MOVE, oas_pkg::OAS_AM_IND_OFS16, 1, 0, 16'h0100, 0);
		chk(acc(), 18'h20111);
		issue(oas_pkg::OAS_OP_MOVE, oas_pkg::OAS_AM_IND_NOUPD, 1, 0, 0, 0);
		chk(acc(), 18'h20011);
	endtask

	// Call pushes two words; a request while busy is dropped
	task automatic t_call();
		@(posedge i_clock);
		#1;
		i_req.op = oas_pkg::OAS_OP_CALL;
		i_req.mode = oas_pkg::OAS_AM_REG;
		i_valid = 1'b1;
		@(posedge i_clock);
		#1;
		// Strobe held high into the busy cycle so the refusal is exercised
		i_req.op = oas_pkg::OAS_OP_LEA_SP;
		i_req.reg_val = 16'h0004;
		chk({o_busy, o_mem.wr, o_mem.addr}, 18'h30001);
		chk(o_mem.wdata, 18'h00abc);
		@(posedge i_clock);
		#1;
		i_valid = 1'b0;
		chk({o_mem.wr, o_mem.addr}, 18'h10002);
		chk(o_mem.wdata, 18'h05a5a);
		@(posedge i_clock);
		#1;
		chk(o_stack_pointer, 18'h00002);
	endtask

	task automatic t_stack();
		// Even step only, as software must keep the pointer even
		issue(oas_pkg::OAS_OP_LEA_SP, oas_pkg::OAS_AM_REG, 0, 0, 0, 16'h0006);
		chk(o_stack_pointer, 18'h00008);
		issue(oas_pkg::OAS_OP_MOVE, oas_pkg::OAS_AM_STACK_REL, 0, 6'h03, 0, 0);
		chk({o_mem.rd, o_mem.addr}, 18'h10005);
		chk(o_stack_pointer, 18'h00008);
		issue(oas_pkg::OAS_OP_ADD, oas_pkg::OAS_AM_STACK_REL, 0, 6'h07, 0, 0);
		chk({o_mem.rd, o_mem.addr}, 18'h10001);
	endtask

	// Memory loop counter at word 3 counts down to zero
	task automatic t_loop();
		for (int k = 2; k >= 0; k--)
		begin
			issue(oas_pkg::OAS_OP_DECREMENT_MEMORY_WORD, oas_pkg::OAS_AM_ABS6, 0, 6'h03, 0, 0);
			chk({o_mem.rd, o_mem.addr}, 18'h10003);
			@(posedge i_clock);
			#1;
			chk({o_mem.wr, o_mem.addr}, 18'h10003);
			chk(o_mem.wdata, k);
			issue(oas_pkg::OAS_OP_BGT, oas_pkg::OAS_AM_REG, 0, 0, 0, 0);
			chk(o_branch_taken, k > 0);
		end
	endtask

	// ==========================================================
	// Main sequence
	initial
	begin
		i_clock = 1'b0;
		i_rst_n = 1'b0;
		i_valid = 1'b0;
		i_req = '0;
		i_pc_ret = 16'h0abc;
		i_status = 16'h5a5a;
		fails = 0;
		n_tests = 0;
		cycles = 0;
		repeat (3) @(posedge i_clock);
		#1;
		i_rst_n = 1'b1;
		chk({o_busy, o_mem.rd, o_stack_pointer}, 18'h00000);
		t_immediate();
		t_add();
		t_pointer();
		t_direct();
		t_call();
		t_stack();
		t_loop();
		finish_test();
	end
endmodule
